/* core/pwmp_pair1_edges.sv */
// Compare-driven edge generator for output pair one and channel five, AXI4-Lite registers
//
// Overview of operation
// [R01] Timer equal to pair-one rise compare drives channel two high.
// [R02] Timer equal to pair-one first fall compare drives channel two low.
// [R03] Timer equal to pair-one second fall compare drives channel three low.
// [R04] Timer equal to pair-two second fall compare drives channel five low.
// [R05] With load bit set, compares copy into active set at timer step 0 to 1.
// [R06] Period length raises channel three and ends the shared timer period.
`timescale 1ns/100ps
module pwmp_pair1_edges import pwmp_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic channel_pair1_a,
    output logic channel_pair1_b,
    output logic channel_pair2_b
);
    function automatic pwmp_sel_type decode(input logic [ADDR_W-1:0] a);
        pwmp_sel_type s;
        s = SEL_NONE;
        if (a == OFS_P1_RISE) s = SEL_P1_RISE;
        if (a == OFS_P1_FALL_A) s = SEL_P1_FALL_A;
        if (a == OFS_P1_FALL_B) s = SEL_P1_FALL_B;
        if (a == OFS_P1_LEN) s = SEL_P1_LEN;
        if (a == OFS_P2_FALL_B) s = SEL_P2_FALL_B;
        if (a == OFS_CTRL) s = SEL_CTRL;
        if (a == OFS_STAT) s = SEL_STAT;
        return s;
    endfunction

    function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
                                                 input logic [DATA_W-1:0] d,
                                                 input logic [STRB_W-1:0] st);
        logic [CNT_W-1:0] r;
        r = old;
        if (st[0]) r[7:0] = d[7:0];
        if (st[1]) r[15:8] = d[15:8];
        return r;
    endfunction

    // Bus-facing state
    logic aw_got_reg, aw_got_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic w_got_reg, w_got_next;
    logic [DATA_W-1:0] w_data_reg, w_data_next;
    logic [STRB_W-1:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [CNT_W-1:0] sw_rise_reg, sw_rise_next;
    logic [CNT_W-1:0] sw_fall_a_reg, sw_fall_a_next;
    logic [CNT_W-1:0] sw_fall_b_reg, sw_fall_b_next;
    logic [CNT_W-1:0] sw_p2_fall_reg, sw_p2_fall_next;
    logic [CNT_W-1:0] len_reg, len_next;
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    // Pattern-facing state
    logic [CNT_W-1:0] act_rise_reg, act_rise_next;
    logic [CNT_W-1:0] act_fall_a_reg, act_fall_a_next;
    logic [CNT_W-1:0] act_fall_b_reg, act_fall_b_next;
    logic [CNT_W-1:0] act_p2_fall_reg, act_p2_fall_next;
    logic out_a_reg, out_a_next;
    logic out_b_reg, out_b_next;
    logic out_p2_reg, out_p2_next;
    logic [CNT_W-1:0] count;
    logic first_step;
    logic run;
    logic load_compare_bit;
    logic do_write;
    pwmp_sel_type wsel;
    pwmp_sel_type rsel;

    assign run = ctrl_reg[CTRL_EN_BIT];
    assign load_compare_bit = ctrl_reg[CTRL_LOAD_BIT];
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;
    assign wsel = decode(aw_addr_reg);
    assign rsel = decode(s_axi_araddr);

    pwmp_timer #(
        .W(CNT_W)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .period_len(len_reg), // R06
        .count(count),
        .first_step(first_step)
    );

    always_comb begin
        aw_got_next = aw_got_reg;
        aw_addr_next = aw_addr_reg;
        w_got_next = w_got_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        sw_rise_next = sw_rise_reg;
        sw_fall_a_next = sw_fall_a_reg;
        sw_fall_b_next = sw_fall_b_reg;
        sw_p2_fall_next = sw_p2_fall_reg;
        len_next = len_reg;
        ctrl_next = ctrl_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            unique case (wsel)
                SEL_P1_RISE: sw_rise_next = merge16(sw_rise_reg, w_data_reg, w_strb_reg);
                SEL_P1_FALL_A: sw_fall_a_next = merge16(sw_fall_a_reg, w_data_reg, w_strb_reg);
                SEL_P1_FALL_B: sw_fall_b_next = merge16(sw_fall_b_reg, w_data_reg, w_strb_reg);
                SEL_P1_LEN: len_next = merge16(len_reg, w_data_reg, w_strb_reg);
                SEL_P2_FALL_B: sw_p2_fall_next = merge16(sw_p2_fall_reg, w_data_reg, w_strb_reg);
                SEL_CTRL: begin
                    if (w_strb_reg[0]) begin
                        ctrl_next = w_data_reg[CTRL_W-1:0];
                    end
                end
                SEL_STAT: bresp_next = RESP_OKAY;
                SEL_NONE: bresp_next = RESP_SLVERR;
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = DATA_ZERO;
            unique case (rsel)
                SEL_P1_RISE: rdata_next[CNT_W-1:0] = sw_rise_reg;
                SEL_P1_FALL_A: rdata_next[CNT_W-1:0] = sw_fall_a_reg;
                SEL_P1_FALL_B: rdata_next[CNT_W-1:0] = sw_fall_b_reg;
                SEL_P1_LEN: rdata_next[CNT_W-1:0] = len_reg;
                SEL_P2_FALL_B: rdata_next[CNT_W-1:0] = sw_p2_fall_reg;
                SEL_CTRL: rdata_next[CTRL_W-1:0] = ctrl_reg;
                SEL_STAT: begin
                    rdata_next[STAT_CNT_LSB +: CNT_W] = count;
                    rdata_next[STAT_A_BIT] = out_a_reg;
                    rdata_next[STAT_B_BIT] = out_b_reg;
                    rdata_next[STAT_P2B_BIT] = out_p2_reg;
                end
                SEL_NONE: rresp_next = RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            aw_addr_reg <= DATA_ZERO;
            w_got_reg <= 1'b0;
            w_data_reg <= DATA_ZERO;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= DATA_ZERO;
            sw_rise_reg <= CMP_RESET;
            sw_fall_a_reg <= CMP_RESET;
            sw_fall_b_reg <= CMP_RESET;
            sw_p2_fall_reg <= CMP_RESET;
            len_reg <= LEN_RESET;
            ctrl_reg <= CTRL_RESET;
        end else begin
            aw_got_reg <= aw_got_next;
            aw_addr_reg <= aw_addr_next;
            w_got_reg <= w_got_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            sw_rise_reg <= sw_rise_next;
            sw_fall_a_reg <= sw_fall_a_next;
            sw_fall_b_reg <= sw_fall_b_next;
            sw_p2_fall_reg <= sw_p2_fall_next;
            len_reg <= len_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // Active compare set and output edges; a fall wins over a rise on the same count
    always_comb begin
        act_rise_next = act_rise_reg;
        act_fall_a_next = act_fall_a_reg;
        act_fall_b_next = act_fall_b_reg;
        act_p2_fall_next = act_p2_fall_reg;
        out_a_next = out_a_reg;
        out_b_next = out_b_reg;
        out_p2_next = out_p2_reg;
        if (load_compare_bit && first_step) begin // R05
            act_rise_next = sw_rise_reg;
            act_fall_a_next = sw_fall_a_reg;
            act_fall_b_next = sw_fall_b_reg;
            act_p2_fall_next = sw_p2_fall_reg;
        end
        if (!run) begin
            out_a_next = 1'b0;
            out_b_next = 1'b0;
            out_p2_next = 1'b0;
        end else begin
            if (count == act_rise_reg) out_a_next = 1'b1; // R01
            if (count == act_fall_a_reg) out_a_next = 1'b0; // R02
            if (count == len_reg) out_b_next = 1'b1; // R06
            if (count == act_fall_b_reg) out_b_next = 1'b0; // R03
            if (count == len_reg) out_p2_next = 1'b1;
            if (count == act_p2_fall_reg) out_p2_next = 1'b0; // R04
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_rise_reg <= CMP_RESET;
            act_fall_a_reg <= CMP_RESET;
            act_fall_b_reg <= CMP_RESET;
            act_p2_fall_reg <= CMP_RESET;
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
            out_p2_reg <= 1'b0;
        end else begin
            act_rise_reg <= act_rise_next;
            act_fall_a_reg <= act_fall_a_next;
            act_fall_b_reg <= act_fall_b_next;
            act_p2_fall_reg <= act_p2_fall_next;
            out_a_reg <= out_a_next;
            out_b_reg <= out_b_next;
            out_p2_reg <= out_p2_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign channel_pair1_a = out_a_reg;
    assign channel_pair1_b = out_b_reg;
    assign channel_pair2_b = out_p2_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence load_step;
        run && load_compare_bit && first_step;
    endsequence
    sequence no_load_step;
        !(load_compare_bit && first_step);
    endsequence

    chk_rise_sets_a: assert property (run && count == act_rise_reg && count != act_fall_a_reg |=> channel_pair1_a) // R01
        else $error("channel two did not rise on its compare");
    chk_fall_clears_a: assert property (run && count == act_fall_a_reg |=> !channel_pair1_a) // R02
        else $error("channel two did not fall on its compare");
    chk_fall_clears_b: assert property (run && count == act_fall_b_reg |=> !channel_pair1_b) // R03
        else $error("channel three did not fall on its compare");
    chk_p2_fall: assert property (run && count == act_p2_fall_reg |=> !channel_pair2_b) // R04
        else $error("channel five did not fall on its compare");
    chk_shadow_load: assert property (load_step |=> act_rise_reg == $past(sw_rise_reg) && count == CNT_ONE) // R05
        else $error("compare set not loaded at timer step");
    chk_shadow_hold: assert property (no_load_step |=> $stable(act_fall_a_reg) && $stable(act_fall_b_reg)) // R05
        else $error("active compare changed without a load");
    chk_len_rise_b: assert property (run && count == len_reg && count != act_fall_b_reg |=> channel_pair1_b) // R06
        else $error("channel three did not rise at period length");
    chk_period_wrap: assert property (run && count == len_reg ##1 run |-> count == CNT_ZERO) // R06
        else $error("timer did not wrap after period length");
    chk_write_resp: assert property (do_write |=> s_axi_bvalid && !aw_got_reg && !w_got_reg)
        else $error("write response missing");
endmodule // pwmp_pair1_edges

/* inc/pwmp_pkg.sv */
// Constants and types shared by the pair-one compare edge generator
package pwmp_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int CNT_W = 16;
    localparam logic [ADDR_W-1:0] OFS_P1_RISE = 32'hFFFF0F94;
    localparam logic [ADDR_W-1:0] OFS_P1_FALL_A = 32'hFFFF0F98;
    localparam logic [ADDR_W-1:0] OFS_P1_FALL_B = 32'hFFFF0F9C;
    localparam logic [ADDR_W-1:0] OFS_P1_LEN = 32'hFFFF0FA0;
    localparam logic [ADDR_W-1:0] OFS_P2_FALL_B = 32'hFFFF0FAC;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 32'hFFFF0FC0;
    localparam logic [ADDR_W-1:0] OFS_STAT = 32'hFFFF0FC4;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_LOAD_BIT = 1;
    localparam int CTRL_W = 2;
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_A_BIT = 16;
    localparam int STAT_B_BIT = 17;
    localparam int STAT_P2B_BIT = 18;
    localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] LEN_RESET = 16'hFFFF;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
    typedef enum logic [2:0] {
        SEL_P1_RISE,
        SEL_P1_FALL_A,
        SEL_P1_FALL_B,
        SEL_P1_LEN,
        SEL_P2_FALL_B,
        SEL_CTRL,
        SEL_STAT,
        SEL_NONE
    } pwmp_sel_type;
endpackage

/* core/pwmp_timer.sv */
// Shared up-counting timer for the pair, wrapping after the period length
`timescale 1ns/100ps
module pwmp_timer import pwmp_pkg::*; #(
    parameter int W = CNT_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [W-1:0] period_len,
    output logic [W-1:0] count,
    output logic first_step
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (!run) begin
            count_next = W'(CNT_ZERO);
        end else if (count_reg == period_len) begin
            count_next = W'(CNT_ZERO);
        end else begin
            count_next = count_reg + W'(CNT_ONE);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= W'(CNT_ZERO);
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
    // Next edge moves the count from zero to one
    assign first_step = run && (count_reg == W'(CNT_ZERO)) && (period_len != W'(CNT_ZERO));
endmodule // pwmp_timer

/* dv/pwmp_load_model.sv */
// Load model on the three outputs, counting rising edges
`timescale 1ns/100ps
module pwmp_load_model (
    input wire logic aclk,
    input wire logic clr,
    input wire logic ch_a,
    input wire logic ch_b,
    input wire logic ch_c,
    output logic [15:0] rises_a,
    output logic [15:0] rises_b,
    output logic [15:0] rises_c
);
    logic [2:0] last_reg;
    always_ff @(posedge aclk) begin
        last_reg <= {ch_c, ch_b, ch_a};
        if (clr) begin
            rises_a <= 16'h0;
            rises_b <= 16'h0;
            rises_c <= 16'h0;
        end else begin
            rises_a <= rises_a + {15'h0, ch_a & ~last_reg[0]};
            rises_b <= rises_b + {15'h0, ch_b & ~last_reg[1]};
            rises_c <= rises_c + {15'h0, ch_c & ~last_reg[2]};
        end
    end
endmodule // pwmp_load_model

/* dv/pwmp_pair1_edges_tb.sv */
// Testbench for the pair-one compare edge generator
`timescale 1ns/100ps
module pwmp_pair1_edges_tb import pwmp_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic channel_pair1_a, channel_pair1_b, channel_pair2_b;
    logic clr = 1'b1;
    logic [15:0] rises_a, rises_b, rises_c;
    int bad_count = 0;
    int total_checks = 0;
    logic [31:0] d;
    logic [31:0] ra [6] = '{OFS_P1_RISE, OFS_P1_FALL_A, OFS_P1_FALL_B, OFS_P1_LEN, OFS_P2_FALL_B, OFS_CTRL};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0000FFFF, 32'h0, 32'h0};

    pwmp_pair1_edges i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .channel_pair1_a(channel_pair1_a),
        .channel_pair1_b(channel_pair1_b), .channel_pair2_b(channel_pair2_b));
    pwmp_load_model i_load (.aclk(aclk), .clr(clr), .ch_a(channel_pair1_a), .ch_b(channel_pair1_b),
        .ch_c(channel_pair2_b), .rises_a(rises_a), .rises_b(rises_b), .rises_c(rises_c));

    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_data({30'h0, got}, {30'h0, exp});
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                chk_resp(s_axi_bresp, er);
                n = 1000;
            end
        end
        s_axi_bready <= 1'b0;
        if (n < 1000) bad_count++;
    endtask

    task automatic rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] q);
        int n;
        n = 0;
        q = 32'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                q = s_axi_rdata;
                chk_resp(s_axi_rresp, er);
                n = 1000;
            end
        end
        s_axi_rready <= 1'b0;
        if (n < 1000) bad_count++;
    endtask

    function automatic bit near(input logic [15:0] c, input logic [15:0] b);
        int k;
        k = int'(c) - int'(b);
        return k >= -5 && k <= 5;
    endfunction

    task automatic wait_wrap();
        logic [31:0] q;
        logic [15:0] last;
        int n;
        rd(OFS_STAT, RESP_OKAY, q);
        last = q[15:0];
        for (n = 0; n < 200; n++) begin
            rd(OFS_STAT, RESP_OKAY, q);
            if (q[15:0] < last) n = 1000;
            last = q[15:0];
        end
        if (n < 1000) bad_count++;
    endtask

    // Polls the timer and compares status bits and pins with the compare edges
    task automatic sample(input logic [15:0] r, fa, fb, p2, len);
        logic [31:0] q;
        logic [2:0] e;
        logic [2:0] pins;
        logic [15:0] c;
        repeat (40) begin
            rd(OFS_STAT, RESP_OKAY, q);
            pins = {channel_pair2_b, channel_pair1_b, channel_pair1_a};
            c = q[15:0];
            e = {c <= p2, c <= fb, c > r && c <= fa};
            if (!(near(c, r) || near(c, fa) || near(c, fb) || near(c, p2) || near(c, 16'h0) || near(c, len))) begin
                chk_data({29'h0, q[18:16]}, {29'h0, e});
                chk_data({29'h0, pins}, {29'h0, e});
            end
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ra[i]) begin
            rd(ra[i], RESP_OKAY, d);
            chk_data(d, rv[i]);
        end
        rd(32'hFFFF0FB0, RESP_SLVERR, d);
        chk_data(d, DATA_ZERO);
        wr(32'hFFFF0FB0, 32'h00001111, 4'hF, RESP_SLVERR);
        wr(OFS_STAT, 32'h0000FFFF, 4'hF, RESP_OKAY);
        rd(OFS_STAT, RESP_OKAY, d);
        chk_data(d, DATA_ZERO);
        wr(OFS_P1_RISE, 32'hFFFF1234, 4'hF, RESP_OKAY);
        rd(OFS_P1_RISE, RESP_OKAY, d);
        chk_data(d, 32'h00001234);
        wr(OFS_P1_RISE, 32'h0000AB99, 4'h2, RESP_OKAY);
        rd(OFS_P1_RISE, RESP_OKAY, d);
        chk_data(d, 32'h0000AB34);
        $display("test registers done");
        wr(OFS_P1_RISE, 32'h14, 4'hF, RESP_OKAY);
        wr(OFS_P1_FALL_A, 32'h3C, 4'hF, RESP_OKAY);
        wr(OFS_P1_FALL_B, 32'h28, 4'hF, RESP_OKAY);
        wr(OFS_P2_FALL_B, 32'h46, 4'hF, RESP_OKAY);
        wr(OFS_P1_LEN, 32'h63, 4'hF, RESP_OKAY);
        wr(OFS_CTRL, 32'h3, 4'h1, RESP_OKAY);
        wait_wrap();
        @(posedge aclk);
        clr <= 1'b0;
        wait_wrap();
        chk_data({16'h0, rises_a}, 32'h1);
        chk_data({16'h0, rises_b}, 32'h1);
        chk_data({16'h0, rises_c}, 32'h1);
        sample(16'h14, 16'h3C, 16'h28, 16'h46, 16'h63);
        $display("test edges done");
        wr(OFS_CTRL, 32'h1, 4'h1, RESP_OKAY);
        wr(OFS_P1_RISE, 32'h1E, 4'hF, RESP_OKAY);
        wr(OFS_P1_FALL_A, 32'h32, 4'hF, RESP_OKAY);
        wait_wrap();
        sample(16'h14, 16'h3C, 16'h28, 16'h46, 16'h63);
        wr(OFS_CTRL, 32'h3, 4'h1, RESP_OKAY);
        wait_wrap();
        sample(16'h1E, 16'h32, 16'h28, 16'h46, 16'h63);
        $display("test load done");
        close_out();
    end
endmodule // pwmp_pair1_edges_tb
